// File: hdl/racc_consts.svh
// register map, field layout, reset values and timing constants for the radio framing config
// Behaviour
// [R1] transmit uses the logical address chosen by the select field, latched at start.
// [R2] prefix byte n comes from byte field n, field zero lowest, latched at start.
// [R3] checksum length is one to three bytes; zero disables checksum entirely.
// [R4] with the exclude control clear, the address is covered by the checksum.
// [R5] with the exclude control set, checksum starts at the first byte after address.
// [R6] inter-frame gap is counted in microseconds from last bit to next first bit.
// [R7] programmed gap is latched at start; later writes wait for next start.
// [R8] signal strength reads as a read-only unsigned magnitude from zero to 127.
// [R9] software reads the magnitude as minus that many dBm.
// [R10] a dedicated control picks address coverage by the checksum, latched at start.
// [R11] reception is accepted only on logical addresses whose enable bit was set at start.
`ifndef RACC_CONSTS_SVH
`define RACC_CONSTS_SVH

`define RACC_ADDR_BASE_ADDRESS_ZERO    8'h00
`define RACC_ADDR_BASE_ADDRESS_ONE    8'h04
`define RACC_ADDR_PREFIX_BYTES_LOW  8'h08
`define RACC_ADDR_PREFIX_BYTES_HIGH  8'h0C
`define RACC_ADDR_TXSEL    8'h10
`define RACC_ADDR_RXEN     8'h14
`define RACC_ADDR_CKCFG    8'h18
`define RACC_ADDR_CKPOLY   8'h1C
`define RACC_ADDR_CKSEED   8'h20
`define RACC_ADDR_TEST     8'h24
`define RACC_ADDR_GAP      8'h28
`define RACC_ADDR_RSSI     8'h2C
`define RACC_ADDR_START    8'h30
`define RACC_ADDR_STATUS   8'h34

`define RACC_RST_WORD      32'h0000_0000
`define RACC_RST_POLY      24'h00_0000
`define RACC_CK_LEN_LSB    0
`define RACC_CK_LEN_W      2
`define RACC_CK_SKIP_BIT   8
`define RACC_TEST_TONE_BIT 0
`define RACC_TEST_LOCK_BIT 1
`define RACC_GAP_W         8
`define RACC_RSSI_W        7
`define RACC_SEL_W         3
`define RACC_SEED_W        24
`define RACC_UNMAPPED      32'h0000_0000
`define RACC_US_NS         1000
`define RACC_CLK_NS        40
`define RACC_CYC_PER_US    (`RACC_US_NS / `RACC_CLK_NS)

`endif

// File: hdl/racc_pkg.sv
// types for the radio framing config block
package racc_pkg;
	typedef enum logic [2:0] {
		RACC_IDLE = 3'b001,
		RACC_GAP  = 3'b010,
		RACC_OUT  = 3'b100
	} racc_state_t;
	typedef logic [1:0] racc_cklen_t;
endpackage

// File: hdl/racc_top.sv
// framing configuration registers, start-task latching and gap timer
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "racc_consts.svh"
module racc_top (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       clk_en,
	input  wire logic [7:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic                       start_task,
	input  wire logic                       packet_end,
	input  wire logic [6:0]                 rssi_in,
	input  wire logic                       rssi_valid,
	input  wire logic [2:0]                 rx_logical,
	input  wire logic                       rx_valid,
	output logic                            rx_accept,
	output logic                            cfg_valid,
	input  wire logic                       cfg_ready,
	output logic      [31:0]                tx_base,
	output logic      [7:0]                 tx_prefix,
	output logic      [2:0]                 transmit_logical_select,
	output logic      [7:0]                 receive_logical_enables,
	output racc_pkg::racc_cklen_t           checksum_byte_count,
	output logic                            checksum_enable,
	output logic                            checksum_address_exclude,
	output logic      [23:0]                checksum_poly_value,
	output logic      [23:0]                checksum_seed_value,
	output logic                            steady_tone_enable,
	output logic                            synth_lock_enable,
	output logic                            gap_busy,
	output logic                            gap_done
);
	import racc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// software registers
	logic [31:0] base_address_zero;
	logic [31:0] base_address_one;
	logic [31:0] prefix_bytes_low;
	logic [31:0] prefix_bytes_high;
	logic [2:0]  transmit_address_select;
	logic [7:0]  receive_address_enables;
	logic [8:0]  checksum_config;
	logic [23:0] checksum_polynomial;
	logic [23:0] checksum_seed;
	logic [1:0]  test_controls;
	logic [7:0]  interframe_gap;
	logic [6:0]  signal_strength_sample;

	// asynchronous pins: two-stage synchronisers
	logic       start_s1, start_s2, start_s3;
	logic       end_s1, end_s2, end_s3;
	logic [6:0] rssi_s1, rssi_s2;
	logic       rssiv_s1, rssiv_s2, rssiv_s3;

	always_ff @(posedge mclk) begin
		if (rst) begin
			start_s1 <= 1'b0;
			start_s2 <= 1'b0;
			start_s3 <= 1'b0;
			end_s1   <= 1'b0;
			end_s2   <= 1'b0;
			end_s3   <= 1'b0;
			rssi_s1  <= 7'h00;
			rssi_s2  <= 7'h00;
			rssiv_s1 <= 1'b0;
			rssiv_s2 <= 1'b0;
			rssiv_s3 <= 1'b0;
		end else if (clk_en) begin
			start_s1 <= start_task;
			start_s2 <= start_s1;
			start_s3 <= start_s2;
			end_s1   <= packet_end;
			end_s2   <= end_s1;
			end_s3   <= end_s2;
			rssi_s1  <= rssi_in;
			rssi_s2  <= rssi_s1;
			rssiv_s1 <= rssi_valid;
			rssiv_s2 <= rssiv_s1;
			rssiv_s3 <= rssiv_s2;
		end
	end

	wire sw_start  = avs_write && !avs_waitrequest && (avs_address == `RACC_ADDR_START)
		&& avs_writedata[0] && avs_byteenable[0];
	wire start_evt = (start_s2 && !start_s3) || sw_start;
	wire end_evt   = end_s2 && !end_s3;

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then the access completes
	logic ack;
	wire  req    = (avs_read || avs_write) && clk_en;
	wire  wr_go  = avs_write && ack;
	// a frozen clock must not complete a transfer that cannot land
	assign avs_waitrequest = !(ack && clk_en);

	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	always_ff @(posedge mclk) begin
		if (rst) begin
			ack <= 1'b0;
		end else if (clk_en) begin
			ack <= req && !ack;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			base_address_zero       <= `RACC_RST_WORD;
			base_address_one        <= `RACC_RST_WORD;
			prefix_bytes_low        <= `RACC_RST_WORD;
			prefix_bytes_high       <= `RACC_RST_WORD;
			transmit_address_select <= 3'h0;
			receive_address_enables <= 8'h00;
			checksum_config         <= 9'h000;
			checksum_polynomial     <= `RACC_RST_POLY;
			checksum_seed           <= 24'h00_0000;
			test_controls           <= 2'h0;
			interframe_gap          <= 8'h00;
		end else if (clk_en && wr_go) begin
			case (avs_address)
			`RACC_ADDR_BASE_ADDRESS_ZERO: begin
				base_address_zero <= merge(base_address_zero, avs_writedata, be_mask);
			end
			`RACC_ADDR_BASE_ADDRESS_ONE: begin
				base_address_one <= merge(base_address_one, avs_writedata, be_mask);
			end
			`RACC_ADDR_PREFIX_BYTES_LOW: begin
				prefix_bytes_low <= merge(prefix_bytes_low, avs_writedata, be_mask);
			end
			`RACC_ADDR_PREFIX_BYTES_HIGH: begin
				prefix_bytes_high <= merge(prefix_bytes_high, avs_writedata, be_mask);
			end
			`RACC_ADDR_TXSEL: begin
				if (avs_byteenable[0]) transmit_address_select <= avs_writedata[2:0];
			end
			`RACC_ADDR_RXEN: begin
				if (avs_byteenable[0]) receive_address_enables <= avs_writedata[7:0];
			end
			`RACC_ADDR_CKCFG: begin
				if (avs_byteenable[0]) checksum_config[1:0] <= avs_writedata[1:0];
				if (avs_byteenable[1]) checksum_config[8] <= avs_writedata[8];
			end
			`RACC_ADDR_CKPOLY: begin
				checksum_polynomial <= 24'(merge({8'h00, checksum_polynomial},
					avs_writedata, be_mask));
			end
			`RACC_ADDR_CKSEED: begin
				checksum_seed <= 24'(merge({8'h00, checksum_seed}, avs_writedata, be_mask));
			end
			`RACC_ADDR_TEST: begin
				if (avs_byteenable[0]) test_controls <= avs_writedata[1:0];
			end
			`RACC_ADDR_GAP: begin
				if (avs_byteenable[0]) interframe_gap <= avs_writedata[7:0];
			end
			default: begin
			end
			endcase
		end
	end

	// read-only magnitude; strobe seen twice so the data bits have settled
	always_ff @(posedge mclk) begin
		if (rst) begin
			signal_strength_sample <= 7'h00;
		end else if (clk_en && rssiv_s2 && rssiv_s3) begin
			signal_strength_sample <= rssi_s2; // R8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start-task snapshot, passed through a two-entry buffer to the radio
	localparam int CW = 32 + 8 + 3 + 8 + 2 + 1 + 24 + 24 + 2;
	logic [CW-1:0] buf_q [2];
	logic          wp, rp;
	logic [1:0]    cnt;

	wire [7:0] sel_prefix = (transmit_address_select[2])
		? prefix_bytes_high[{transmit_address_select[1:0], 3'b000} +: 8]
		: prefix_bytes_low[{transmit_address_select[1:0], 3'b000} +: 8]; // R2
	wire [31:0] sel_base = (transmit_address_select == 3'h0)
		? base_address_zero : base_address_one; // R1
	wire [CW-1:0] snap = {sel_base, sel_prefix, transmit_address_select, // R1
		receive_address_enables, checksum_config[1:0], checksum_config[8], // R10
		checksum_polynomial, checksum_seed, test_controls};
	wire in_fire  = start_evt && (cnt != 2'd2);
	wire out_fire = cfg_valid && cfg_ready;
	assign cfg_valid = (cnt != 2'd0);

	always_ff @(posedge mclk) begin
		if (rst) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'd0;
		end else if (clk_en) begin
			if (in_fire) wp <= ~wp;
			if (out_fire) rp <= ~rp;
			cnt <= 2'(cnt + {1'b0, in_fire} - {1'b0, out_fire});
		end
	end

	always_ff @(posedge mclk) begin
		if (clk_en && in_fire) buf_q[wp] <= snap;
	end

	// entry copied from the head at the last handshake drives the radio; held values until the next start is drained
	logic [CW-1:0] cur;
	always_ff @(posedge mclk) begin
		if (rst) begin
			cur <= '0;
		end else if (clk_en && out_fire) begin
			cur <= buf_q[rp];
		end
	end

	assign tx_base                  = cur[CW-1 -: 32];
	assign tx_prefix                = cur[CW-33 -: 8];
	assign transmit_logical_select  = cur[CW-41 -: 3];
	assign receive_logical_enables  = cur[CW-44 -: 8];
	assign checksum_byte_count      = cur[CW-52 -: 2]; // R3
	assign checksum_enable          = (cur[CW-52 -: 2] != 2'd0); // R3
	assign checksum_address_exclude = cur[CW-54]; // R4 R5 R10
	assign checksum_poly_value      = cur[CW-55 -: 24];
	assign checksum_seed_value      = cur[CW-79 -: 24];
	assign steady_tone_enable       = cur[`RACC_TEST_TONE_BIT];
	assign synth_lock_enable        = cur[`RACC_TEST_LOCK_BIT];
	assign rx_accept = rx_valid && receive_logical_enables[rx_logical]; // R11

	////////////////////////////////////////////////////////////////////////
	// inter-frame gap timer: counts microseconds from end of packet
	racc_state_t state, next_state;
	logic [7:0]  gap_lat;
	logic [7:0]  us_cnt;
	logic [7:0]  gap_cnt;
	wire         us_tick = (us_cnt == 8'(`RACC_CYC_PER_US - 1));

	always_ff @(posedge mclk) begin
		if (rst) begin
			gap_lat <= 8'h00;
		end else if (clk_en && start_evt) begin
			gap_lat <= interframe_gap; // R7
		end
	end

	always_comb begin
		next_state = state;
		case (state)
		RACC_IDLE: if (end_evt) next_state = RACC_GAP; // R6
		RACC_GAP:  if (gap_cnt == gap_lat) next_state = RACC_OUT; // R6
		RACC_OUT:  next_state = RACC_IDLE;
		default:   next_state = RACC_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state   <= RACC_IDLE;
			us_cnt  <= 8'h00;
			gap_cnt <= 8'h00;
		end else if (clk_en) begin
			state   <= next_state;
			// primed to one outside the gap so the compare cycle fits the span
			if (state != RACC_GAP) us_cnt <= 8'h01;
			else if (us_tick) us_cnt <= 8'h00;
			else us_cnt <= 8'(us_cnt + 8'h01);
			if (state != RACC_GAP) gap_cnt <= 8'h00;
			else if (us_tick) gap_cnt <= 8'(gap_cnt + 8'h01); // R6
		end
	end

	assign gap_busy = (state == RACC_GAP);
	assign gap_done = (state == RACC_OUT);

	////////////////////////////////////////////////////////////////////////
	// read mux
	logic [31:0] rd;
	always_comb begin
		case (avs_address)
		`RACC_ADDR_BASE_ADDRESS_ZERO:   rd = base_address_zero;
		`RACC_ADDR_BASE_ADDRESS_ONE:   rd = base_address_one;
		`RACC_ADDR_PREFIX_BYTES_LOW: rd = prefix_bytes_low;
		`RACC_ADDR_PREFIX_BYTES_HIGH: rd = prefix_bytes_high;
		`RACC_ADDR_TXSEL:   rd = {29'h0, transmit_address_select};
		`RACC_ADDR_RXEN:    rd = {24'h0, receive_address_enables};
		`RACC_ADDR_CKCFG:   rd = {23'h0, checksum_config};
		`RACC_ADDR_CKPOLY:  rd = {8'h00, checksum_polynomial};
		`RACC_ADDR_CKSEED:  rd = {8'h00, checksum_seed};
		`RACC_ADDR_TEST:    rd = {30'h0, test_controls};
		`RACC_ADDR_GAP:     rd = {24'h0, interframe_gap};
		`RACC_ADDR_RSSI:    rd = {25'h0, signal_strength_sample}; // R8
		`RACC_ADDR_STATUS:  rd = {22'h0, gap_lat, cnt};
		default:            rd = `RACC_UNMAPPED;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en && avs_read && !ack) begin
			avs_readdata <= rd;
		end
	end
endmodule
`default_nettype wire

// File: verif/racc_props.sv
// port checker for the radio framing config block
`timescale 1ns/1ps
`default_nettype none
`include "racc_consts.svh"
module racc_props (
	input wire logic                  mclk,
	input wire logic                  rst,
	input wire logic [7:0]            avs_address,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic [31:0]           avs_readdata,
	input wire logic                  avs_waitrequest,
	input wire logic                  rx_valid,
	input wire logic                  rx_accept,
	input wire logic                  cfg_valid,
	input wire logic                  cfg_ready,
	input wire logic [7:0]            tx_prefix,
	input wire logic [2:0]            transmit_logical_select,
	input wire racc_pkg::racc_cklen_t checksum_byte_count,
	input wire logic                  checksum_enable,
	input wire logic                  checksum_address_exclude,
	input wire logic [23:0]           checksum_poly_value,
	input wire logic                  gap_busy,
	input wire logic                  gap_done
);
	import racc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	a_len_zero_off: assert property (checksum_enable == (checksum_byte_count != 2'h0))
		else $error("checksum enable disagrees with length");
	a_accept_needs_valid: assert property (rx_accept |-> rx_valid)
		else $error("accept without a received packet");
	// start snapshots only move on a taken handshake
	a_cfg_held: assert property (!$past(cfg_valid && cfg_ready) |-> $stable({tx_prefix,
		transmit_logical_select, checksum_address_exclude, checksum_poly_value}))
		else $error("configuration changed without handshake");
	a_buf_holds: assert property (cfg_valid && !cfg_ready |=> cfg_valid)
		else $error("buffered snapshot lost while stalled");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_rssi_range: assert property (avs_read && !avs_waitrequest &&
		avs_address == `RACC_ADDR_RSSI |-> avs_readdata[31:7] == 25'h000_0000)
		else $error("signal strength above seven bits");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
		avs_address > `RACC_ADDR_STATUS |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_gap_pulse: assert property (gap_done |-> $past(gap_busy) ##1 !gap_done)
		else $error("gap done not a single pulse after busy");
	c_handshake: cover property (cfg_valid && cfg_ready);
	c_gap_done: cover property (gap_done);
	c_accept: cover property (rx_accept);
endmodule
bind racc_top racc_props u_props (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .rx_valid, .rx_accept, .cfg_valid, .cfg_ready, .tx_prefix,
	.transmit_logical_select, .checksum_byte_count, .checksum_enable, .checksum_address_exclude,
	.checksum_poly_value, .gap_busy, .gap_done);
`default_nettype wire

// File: verif/racc_radio_model.sv
// radio core model that takes configuration snapshots, with a stall control
`timescale 1ns/1ps
`default_nettype none
module racc_radio_model (
	input wire logic  mclk,
	input wire logic  rst,
	input wire logic  cfg_valid,
	input wire logic  stall,
	output logic      cfg_ready,
	output logic [7:0] taken
);
	// ready is registered, so it never waits on valid
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_ready <= 1'b0;
			taken <= 8'h00;
		end else begin
			cfg_ready <= ~stall;
			if (cfg_valid && cfg_ready) begin
				taken <= taken + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the radio framing config block
`timescale 1ns/1ps
`default_nettype none
`include "racc_consts.svh"
module tb_top;
	import racc_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        avs_read = 1'b0, avs_write = 1'b0, start_task = 1'b0, packet_end = 1'b0;
	logic        rssi_valid = 1'b0, rx_valid = 1'b0, stall = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [6:0]  rssi_in = 7'h00;
	logic [2:0]  rx_logical = 3'h0;
	logic [31:0] avs_readdata, tx_base;
	logic [23:0] poly, seed;
	logic [7:0]  tx_prefix, rx_en, taken;
	logic [2:0]  tsel;
	racc_cklen_t cklen;
	logic        wreq, rx_accept, cfg_valid, cfg_ready, ck_en, ck_ex, tone, lock, gap_busy, gap_done;
	int          fails = 0, compares = 0;
	always #20 mclk = ~mclk;
	racc_top dut (.mclk(mclk), .rst(rst), .clk_en(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(wreq),
		.start_task(start_task), .packet_end(packet_end), .rssi_in(rssi_in),
		.rssi_valid(rssi_valid), .rx_logical(rx_logical), .rx_valid(rx_valid),
		.rx_accept(rx_accept), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .tx_base(tx_base),
		.tx_prefix(tx_prefix), .transmit_logical_select(tsel), .receive_logical_enables(rx_en),
		.checksum_byte_count(cklen), .checksum_enable(ck_en), .checksum_address_exclude(ck_ex),
		.checksum_poly_value(poly), .checksum_seed_value(seed), .steady_tone_enable(tone),
		.synth_lock_enable(lock), .gap_busy(gap_busy), .gap_done(gap_done));
	racc_radio_model radio (.mclk(mclk), .rst(rst), .cfg_valid(cfg_valid), .stall(stall),
		.cfg_ready(cfg_ready), .taken(taken));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// request held to the rising edge that samples waitrequest low, released at that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge mclk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk("bus answer", 1, 32'(n < 50));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk("read data", e, q);
	endtask
	task automatic go();
		logic [7:0] t0;
		int n;
		t0 = taken;
		n = 0;
		@(posedge mclk);
		start_task <= 1'b1;
		repeat (4) @(posedge mclk);
		start_task <= 1'b0;
		while (taken === t0 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		chk("start taken", 1, 32'(n < 40));
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		for (int a = 0; a <= 'h2C; a += 4) rd(8'(a), 32'h0000_0000);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0000_0000);
		wr(`RACC_ADDR_RSSI, 32'h0000_007F);
		rd(`RACC_ADDR_RSSI, 32'h0000_0000);
	endtask
	task automatic t_sweep();
		wr(`RACC_ADDR_BASE_ADDRESS_ZERO, 32'h1234_5678);
		wr(`RACC_ADDR_BASE_ADDRESS_ONE, 32'h9ABC_DEF0);
		wr(`RACC_ADDR_PREFIX_BYTES_LOW, 32'h4433_2211);
		wr(`RACC_ADDR_PREFIX_BYTES_HIGH, 32'h8877_6655);
		rd(`RACC_ADDR_PREFIX_BYTES_HIGH, 32'h8877_6655);
		wr(`RACC_ADDR_CKPOLY, 32'h0012_3456);
		wr(`RACC_ADDR_CKSEED, 32'h00AB_CDEF);
		for (int i = 0; i < 8; i++) begin
			wr(`RACC_ADDR_TXSEL, 32'(i));
			wr(`RACC_ADDR_CKCFG, 32'((i % 2) * 256 + i % 4));
			wr(`RACC_ADDR_TEST, 32'(i % 4));
			go();
			chk("test bits", 32'(i % 4), 32'({lock, tone}));
			chk("base", (i == 0) ? 32'h1234_5678 : 32'h9ABC_DEF0, tx_base);
			chk("prefix", 32'((i + 1) * 17), 32'(tx_prefix));
			chk("select", 32'(i), 32'(tsel));
			chk("length", 32'(i % 4), 32'(cklen));
			chk("enable", 32'(i % 4 != 0), 32'(ck_en));
			chk("exclude", 32'(i % 2), 32'(ck_ex));
		end
		chk("poly", 32'h0012_3456, 32'(poly));
		chk("seed", 32'h00AB_CDEF, 32'(seed));
	endtask
	task automatic t_hold();
		wr(`RACC_ADDR_TXSEL, 32'h0000_0002);
		wr(`RACC_ADDR_CKCFG, 32'h0000_0000);
		wr(`RACC_ADDR_GAP, 32'h0000_0009);
		@(negedge mclk);
		chk("prefix held", 32'h0000_0088, 32'(tx_prefix));
		chk("exclude held", 1, 32'(ck_ex));
		rd(`RACC_ADDR_STATUS, 32'h0000_0000);
	endtask
	task automatic t_gap();
		int n;
		n = 0;
		wr(`RACC_ADDR_GAP, 32'h0000_0003);
		go();
		rd(`RACC_ADDR_STATUS, 32'h0000_000C);
		packet_end <= 1'b1;
		while (gap_busy !== 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		while (gap_busy === 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		chk("gap cycles", 32'(3 * `RACC_CYC_PER_US), 32'(n));
		chk("gap done", 1, 32'(gap_done));
		@(posedge mclk);
		packet_end <= 1'b0;
	endtask
	task automatic t_stall();
		logic [7:0] t0;
		int n;
		n = 0;
		stall <= 1'b1;
		t0 = taken;
		repeat (3) wr(`RACC_ADDR_START, 32'h0000_0001);
		rd(`RACC_ADDR_STATUS, 32'h0000_000E);
		chk("none taken", 32'(t0), 32'(taken));
		stall <= 1'b0;
		while (cfg_valid === 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		chk("two taken", 32'(t0 + 8'h02), 32'(taken));
	endtask
	task automatic t_rssi();
		logic [31:0] q;
		@(posedge mclk);
		rssi_in <= 7'h5A;
		rssi_valid <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(`RACC_ADDR_RSSI, 32'h0000_005A);
		bus(1'b0, `RACC_ADDR_RSSI, 32'h0000_0000, q);
		chk("strength dbm", 32'(-90), 32'(-int'(q[6:0])));
		rssi_in <= 7'h7F;
		repeat (6) @(posedge mclk);
		rd(`RACC_ADDR_RSSI, 32'h0000_007F);
		rssi_valid <= 1'b0;
	endtask
	task automatic t_accept();
		wr(`RACC_ADDR_RXEN, 32'h0000_00A5);
		wr(`RACC_ADDR_TEST, 32'h0000_0003);
		go();
		chk("test bits", 32'h0000_0003, 32'({lock, tone}));
		chk("enables", 32'h0000_00A5, 32'(rx_en));
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			rx_logical <= 3'(i);
			rx_valid <= 1'b1;
			@(negedge mclk);
			chk("accept", 32'((8'hA5 >> i) & 8'h01), 32'(rx_accept));
		end
		@(posedge mclk);
		rx_valid <= 1'b0;
		@(negedge mclk);
		chk("accept idle", 0, 32'(rx_accept));
	endtask
	task automatic end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_sweep();
		t_hold();
		t_gap();
		t_stall();
		t_rssi();
		t_accept();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
